// ### verilog/aicrp_regs.svh
// constants for the two-wire converter control block: setup fields,
// result layout, reset values and timing counts.
// assumes a 5 ns core clock; included by the top module only.
//
// Behaviour
// - setup register is 8 bits, write only, one data byte after address.
// - power-up setup: four input select bits one, other bits zero.
// - setup bits 7..4 enable inputs three..zero, bit 4 is input zero.
// - several enabled inputs convert one per read, ascending from lowest.
// - bit 3 one takes external reference on input three; three inputs left.
// - bit 2 zero filters the bus lines, one bypasses the filter.
// - bits 1 and 0 clear apply delay mechanisms, both set disable them.
// - active delays postpone sampling and bit decisions during bus activity.
// - a bit decision postponed beyond 1 us abandons the conversion.
// - result is 16-bit straight binary, read as two bytes, high first.
// - result holds two zeros, 2-bit input tag, data from bit 11 down.
// - 10-bit variant zeroes two lowest bits, 8-bit variant zeroes four.
// - device answers one fixed 7-bit bus address, set per version.
// - data falling while clock high is a start condition.
// - after start, shift in 7-bit address msb first then direction bit.
// - on address match drive data low for the ninth pulse, else stay idle.
// - direction zero is master write, direction one is master read.
// - each byte is eight data pulses plus acknowledge from the receiver.
// - data changes only with clock low; rising data with clock high stops.
// - read address acknowledge powers up; sample about 0.5 us later.
// - master ack of second byte starts next conversion; nack ends them.
// - high-speed master code is not acknowledged; mode lasts until stop.
`ifndef AICRP_REGS_SVH
`define AICRP_REGS_SVH

`define AICRP_SETUP_RST 8'hf0
`define AICRP_SEL_MSB 7
`define AICRP_SEL_LSB 4
`define AICRP_REF_BIT 3
`define AICRP_FLT_BIT 2
`define AICRP_TRIAL_DLY_BIT 1
`define AICRP_SAMP_DLY_BIT 0
`define AICRP_NO_REF_MASK 4'h7
`define AICRP_TAG_HI 13
`define AICRP_TAG_LO 12
`define AICRP_DATA_MSB 11
`define AICRP_HS_CODE 5'h01

`define AICRP_CLK_NS 5
`define AICRP_WAKE_NS 500
`define AICRP_TRIAL_NS 100
`define AICRP_STALL_NS 1000
`define AICRP_QUIET_NS 50
`define AICRP_WAKE_CYC ((`AICRP_WAKE_NS + `AICRP_CLK_NS - 1) / `AICRP_CLK_NS)
`define AICRP_TRIAL_CYC ((`AICRP_TRIAL_NS + `AICRP_CLK_NS - 1) / `AICRP_CLK_NS)
`define AICRP_STALL_CYC (`AICRP_STALL_NS / `AICRP_CLK_NS)
`define AICRP_QUIET_CYC ((`AICRP_QUIET_NS + `AICRP_CLK_NS - 1) / `AICRP_CLK_NS)

`endif

// ### verilog/aicrp_pkg.sv
// state types for the converter control block.
// assumes nothing beyond the constants header.
`default_nettype none

package aicrp_pkg;

  typedef enum logic [6:0] {
    L_IDLE  = 7'b0000001,
    L_ADDR  = 7'b0000010,
    L_AACK  = 7'b0000100,
    L_WDATA = 7'b0001000,
    L_WACK  = 7'b0010000,
    L_RDATA = 7'b0100000,
    L_RACK  = 7'b1000000
  } aicrp_link_e;

  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_WAKE  = 4'b0010,
    C_SAMP  = 4'b0100,
    C_TRIAL = 4'b1000
  } aicrp_core_e;

endpackage

`default_nettype wire

// ### verilog/aicrp_top.sv
// two-wire slave with setup register and sar conversion sequencer.
// assumes external pull-ups on the bus lines, a comparator output from the
// analogue array, and resetn_i released while both clocks run.
`timescale 1ns/1ps
`include "aicrp_regs.svh"
`default_nettype none

module aicrp_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,
  parameter int RESOLUTION = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic cmp_i,
  output logic power_up_o,
  output logic sample_o,
  output logic [1:0] chan_sel_o,
  output logic [11:0] dac_code_o,
  output logic ext_ref_o,
  output logic hs_mode_o
);

  localparam logic [11:0] DATA_MASK = 12'(12'hfff << (12 - RESOLUTION));
  localparam logic [3:0] LAST_BIT = 4'(12 - RESOLUTION);

  // ----------------------------------------------------------------------
  // link domain reset
  // ----------------------------------------------------------------------
  logic [1:0] lrst_r;
  logic lrstn;

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrstn = lrst_r[1];

  // ----------------------------------------------------------------------
  // line synchronisers and glitch filter
  // ----------------------------------------------------------------------
  logic [7:0] setup_r;
  logic [1:0] pin_w;
  logic [1:0] line_w;

  assign pin_w = {sda_i, scl_i};

  for (genvar gi = 0; gi < 2; gi++) begin : g_line
    logic s1_r;
    logic s2_r;
    logic [1:0] hist_r;
    logic filt_r;
    logic maj_w;
    // majority of three samples rejects single-sample spikes
    assign maj_w = (s2_r & hist_r[0]) | (s2_r & hist_r[1]) |
                   (hist_r[0] & hist_r[1]);
    always_ff @(posedge link_clk_i or negedge lrstn) begin
      if (!lrstn) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        hist_r <= 2'b11;
        filt_r <= 1'b1;
      end else begin
        s1_r <= pin_w[gi];
        s2_r <= s1_r;
        hist_r <= {hist_r[0], s2_r};
        filt_r <= setup_r[`AICRP_FLT_BIT] ? s2_r : maj_w;
      end
    end
    assign line_w[gi] = filt_r;
  end

  // ----------------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------------
  logic scl_w, sda_w, scl_q_r, sda_q_r;
  logic scl_rise, scl_fall, start_w, stop_w;

  assign scl_w = line_w[0];
  assign sda_w = line_w[1];

  always_ff @(posedge link_clk_i or negedge lrstn) begin
    if (!lrstn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_w;
      sda_q_r <= sda_w;
    end
  end

  assign scl_rise = scl_w & ~scl_q_r;
  assign scl_fall = ~scl_w & scl_q_r;
  assign start_w = scl_w & scl_q_r & sda_q_r & ~sda_w;
  assign stop_w = scl_w & scl_q_r & ~sda_q_r & sda_w;

  // ----------------------------------------------------------------------
  // link protocol engine
  // ----------------------------------------------------------------------
  aicrp_pkg::aicrp_link_e lstate_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, tx_r, txlo_r;
  logic rw_r, wfirst_r, lo_next_r, mack_r, sda_drv_r, hs_r;
  logic [15:0] lres_r;
  logic cfg_wr_w, req_w;

  always_ff @(posedge link_clk_i or negedge lrstn) begin
    if (!lrstn) begin
      lstate_r <= aicrp_pkg::L_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      txlo_r <= 8'h00;
      rw_r <= 1'b0;
      wfirst_r <= 1'b0;
      lo_next_r <= 1'b0;
      mack_r <= 1'b0;
      sda_drv_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (stop_w) begin
      lstate_r <= aicrp_pkg::L_IDLE;
      sda_drv_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (start_w) begin
      lstate_r <= aicrp_pkg::L_ADDR;
      bitcnt_r <= 4'h0;
      sda_drv_r <= 1'b0;
    end else begin
      unique case (lstate_r)
        aicrp_pkg::L_IDLE: begin
          sda_drv_r <= 1'b0;
        end
        aicrp_pkg::L_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_w};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (shift_r[7:3] == `AICRP_HS_CODE) begin
              hs_r <= 1'b1;
              lstate_r <= aicrp_pkg::L_IDLE;
            end else if (shift_r[7:1] == SLAVE_ADDR) begin
              rw_r <= shift_r[0];
              sda_drv_r <= 1'b1;
              lstate_r <= aicrp_pkg::L_AACK;
            end else begin
              lstate_r <= aicrp_pkg::L_IDLE;
            end
          end
        end
        aicrp_pkg::L_AACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (rw_r) begin
              // whole word latched so both bytes come from one result
              tx_r <= lres_r[15:8];
              txlo_r <= lres_r[7:0];
              sda_drv_r <= ~lres_r[15];
              lo_next_r <= 1'b1;
              lstate_r <= aicrp_pkg::L_RDATA;
            end else begin
              sda_drv_r <= 1'b0;
              wfirst_r <= 1'b1;
              lstate_r <= aicrp_pkg::L_WDATA;
            end
          end
        end
        aicrp_pkg::L_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_w};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (wfirst_r) begin
              sda_drv_r <= 1'b1;
              wfirst_r <= 1'b0;
              lstate_r <= aicrp_pkg::L_WACK;
            end else begin
              // only one setup byte exists; extra bytes get no ack
              lstate_r <= aicrp_pkg::L_IDLE;
            end
          end
        end
        aicrp_pkg::L_WACK: begin
          if (scl_fall) begin
            sda_drv_r <= 1'b0;
            bitcnt_r <= 4'h0;
            lstate_r <= aicrp_pkg::L_WDATA;
          end
        end
        aicrp_pkg::L_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_r == 4'h7) begin
              sda_drv_r <= 1'b0;
              lstate_r <= aicrp_pkg::L_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_drv_r <= ~tx_r[6];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        aicrp_pkg::L_RACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_w;
          end else if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (!mack_r) begin
              lstate_r <= aicrp_pkg::L_IDLE;
            end else if (lo_next_r) begin
              tx_r <= txlo_r;
              sda_drv_r <= ~txlo_r[7];
              lo_next_r <= 1'b0;
              lstate_r <= aicrp_pkg::L_RDATA;
            end else begin
              tx_r <= lres_r[15:8];
              txlo_r <= lres_r[7:0];
              sda_drv_r <= ~lres_r[15];
              lo_next_r <= 1'b1;
              lstate_r <= aicrp_pkg::L_RDATA;
            end
          end
        end
      endcase
    end
  end

  assign cfg_wr_w = (lstate_r == aicrp_pkg::L_WDATA) && !stop_w &&
                    !start_w && scl_fall && bitcnt_r == 4'h8 && wfirst_r;
  assign req_w = !stop_w && !start_w && scl_fall &&
                 (((lstate_r == aicrp_pkg::L_AACK) && rw_r) ||
                  ((lstate_r == aicrp_pkg::L_RACK) && mack_r &&
                   !lo_next_r));

  // ----------------------------------------------------------------------
  // setup register and link-side toggles
  // ----------------------------------------------------------------------
  logic cfg_t_r, req_t_r, act_t_r;

  always_ff @(posedge link_clk_i or negedge lrstn) begin
    if (!lrstn) begin
      setup_r <= `AICRP_SETUP_RST;
      cfg_t_r <= 1'b0;
    end else if (cfg_wr_w) begin
      setup_r <= shift_r;
      cfg_t_r <= ~cfg_t_r;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrstn) begin
    if (!lrstn) begin
      req_t_r <= 1'b0;
      act_t_r <= 1'b0;
    end else begin
      req_t_r <= req_t_r ^ req_w;
      act_t_r <= act_t_r ^ (scl_rise | scl_fall | (sda_w ^ sda_q_r));
    end
  end

  // result word arrives by toggle; the core holds it stable for microseconds
  logic res_t_r;
  logic [15:0] res_r;
  logic [2:0] res_s_r;

  always_ff @(posedge link_clk_i or negedge lrstn) begin
    if (!lrstn) begin
      res_s_r <= 3'b000;
      lres_r <= 16'h0000;
    end else begin
      res_s_r <= {res_s_r[1:0], res_t_r};
      if (res_s_r[2] ^ res_s_r[1]) begin
        lres_r <= res_r;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drv_r;
  assign hs_mode_o = hs_r;

  // ----------------------------------------------------------------------
  // core domain crossings
  // ----------------------------------------------------------------------
  logic [2:0] cfg_s_r, req_s_r, act_s_r;
  logic [1:0] cmp_s_r;
  logic cfg_ev, req_ev, act_ev;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_s_r <= 3'b000;
      req_s_r <= 3'b000;
      act_s_r <= 3'b000;
      cmp_s_r <= 2'b00;
    end else begin
      cfg_s_r <= {cfg_s_r[1:0], cfg_t_r};
      req_s_r <= {req_s_r[1:0], req_t_r};
      act_s_r <= {act_s_r[1:0], act_t_r};
      cmp_s_r <= {cmp_s_r[0], cmp_i};
    end
  end

  assign cfg_ev = cfg_s_r[2] ^ cfg_s_r[1];
  assign req_ev = req_s_r[2] ^ req_s_r[1];
  assign act_ev = act_s_r[2] ^ act_s_r[1];

  // ----------------------------------------------------------------------
  // core setup copy, sequence restart, bus quiet timer
  // ----------------------------------------------------------------------
  logic [7:0] csetup_r;
  logic restart_r, go_w;
  logic [7:0] quiet_r;
  logic [3:0] en_w;
  logic busy_w;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      csetup_r <= `AICRP_SETUP_RST;
    end else if (cfg_ev) begin
      csetup_r <= setup_r;
    end
  end

  // a setup write landing with a conversion start still restarts
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      restart_r <= 1'b1;
    end else if (cfg_ev) begin
      restart_r <= 1'b1;
    end else if (go_w) begin
      restart_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quiet_r <= 8'h00;
    end else if (act_ev) begin
      quiet_r <= 8'(`AICRP_QUIET_CYC);
    end else if (quiet_r != 8'h00) begin
      quiet_r <= quiet_r - 8'h01;
    end
  end

  assign busy_w = act_ev || quiet_r != 8'h00;
  assign en_w = csetup_r[`AICRP_SEL_MSB:`AICRP_SEL_LSB] &
                (csetup_r[`AICRP_REF_BIT] ? `AICRP_NO_REF_MASK : 4'hf);

  function automatic logic [1:0] pick_chan(input logic [3:0] en,
                                           input logic [1:0] last,
                                           input logic restart);
    logic [1:0] lo;
    logic [1:0] hi;
    logic got_hi;
    lo = 2'd0;
    hi = 2'd0;
    got_hi = 1'b0;
    for (int j = 3; j >= 0; j--) begin
      if (en[j]) begin
        lo = 2'(j);
        if (2'(j) > last) begin
          hi = 2'(j);
          got_hi = 1'b1;
        end
      end
    end
    return (got_hi && !restart) ? hi : lo;
  endfunction

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  aicrp_pkg::aicrp_core_e cstate_r;
  logic [7:0] cnt_r, stall_r;
  logic [3:0] bit_r;
  logic [11:0] code_r, decided_w;
  logic [1:0] chan_r;
  logic sample_r;

  assign go_w = (cstate_r == aicrp_pkg::C_IDLE) && req_ev &&
                en_w != 4'h0;
  assign decided_w = cmp_s_r[1] ? code_r :
                     (code_r & ~(12'h001 << bit_r));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cstate_r <= aicrp_pkg::C_IDLE;
      cnt_r <= 8'h00;
      stall_r <= 8'h00;
      bit_r <= 4'h0;
      code_r <= 12'h000;
      chan_r <= 2'd0;
      sample_r <= 1'b0;
      res_r <= 16'h0000;
      res_t_r <= 1'b0;
    end else begin
      sample_r <= 1'b0;
      unique case (cstate_r)
        aicrp_pkg::C_IDLE: begin
          if (go_w) begin
            chan_r <= pick_chan(en_w, chan_r, restart_r);
            cnt_r <= 8'(`AICRP_WAKE_CYC) - 8'h01;
            cstate_r <= aicrp_pkg::C_WAKE;
          end
        end
        aicrp_pkg::C_WAKE: begin
          if (cnt_r == 8'h00) begin
            cstate_r <= aicrp_pkg::C_SAMP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        aicrp_pkg::C_SAMP: begin
          if (!(busy_w && !csetup_r[`AICRP_SAMP_DLY_BIT])) begin
            sample_r <= 1'b1;
            code_r <= 12'h800;
            bit_r <= 4'd11;
            cnt_r <= 8'(`AICRP_TRIAL_CYC) - 8'h01;
            stall_r <= 8'h00;
            cstate_r <= aicrp_pkg::C_TRIAL;
          end
        end
        aicrp_pkg::C_TRIAL: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (busy_w && !csetup_r[`AICRP_TRIAL_DLY_BIT]) begin
            if (stall_r == 8'(`AICRP_STALL_CYC)) begin
              // held result stays; the master reads the previous word
              cstate_r <= aicrp_pkg::C_IDLE;
            end else begin
              stall_r <= stall_r + 8'h01;
            end
          end else if (bit_r == LAST_BIT) begin
            res_r <= {2'b00, chan_r, decided_w & DATA_MASK};
            res_t_r <= ~res_t_r;
            cstate_r <= aicrp_pkg::C_IDLE;
          end else begin
            code_r <= decided_w | (12'h001 << (bit_r - 4'h1));
            bit_r <= bit_r - 4'h1;
            cnt_r <= 8'(`AICRP_TRIAL_CYC) - 8'h01;
            stall_r <= 8'h00;
          end
        end
      endcase
    end
  end

  assign power_up_o = (cstate_r != aicrp_pkg::C_IDLE);
  assign sample_o = sample_r;
  assign chan_sel_o = chan_r;
  assign dac_code_o = code_r;
  assign ext_ref_o = csetup_r[`AICRP_REF_BIT];

endmodule

`default_nettype wire

// ### bench/aicrp_chk.sv
// assertion checker for the converter control block, bound to its top.
// assumes one reset shared by the core and link clock domains.
`timescale 1ns/1ps
`default_nettype none

module aicrp_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic power_up_o,
  input wire logic sample_o,
  input wire logic [1:0] chan_sel_o,
  input wire logic ext_ref_o,
  input wire logic hs_mode_o
);
  // cycles powered so far in the current conversion
  logic [11:0] up_cnt_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_cnt_r <= 12'h000;
    end else if (power_up_o) begin
      up_cnt_r <= up_cnt_r + 12'h001;
    end else begin
      up_cnt_r <= 12'h000;
    end
  end

  sample_pulse_a:
    assert property (@(posedge clk_i) disable iff (!resetn_i)
      sample_o |=> !sample_o) else $error("sample pulse too long");
  sample_conv_a:
    assert property (@(posedge clk_i) disable iff (!resetn_i)
      sample_o |-> power_up_o) else $error("sample while powered down");
  wake_min_a:
    assert property (@(posedge clk_i) disable iff (!resetn_i)
      sample_o |-> up_cnt_r >= 12'h05a) else $error("sample too early");
  chan_hold_a:
    assert property (@(posedge clk_i) disable iff (!resetn_i)
      power_up_o && $past(power_up_o) && $past(power_up_o, 2)
      |-> $stable(chan_sel_o)) else $error("input changed mid conversion");
  ref_skip_a:
    assert property (@(posedge clk_i) disable iff (!resetn_i)
      ext_ref_o && sample_o |-> chan_sel_o != 2'h3)
      else $error("reference input sampled");
  oe_scl_low_a:
    assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      $changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
  hs_no_ack_a:
    assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      $rose(hs_mode_o) |-> (!sda_oe_o) [*8]) else $error("hs code acked");
  hs_stop_a:
    assert property (@(posedge link_clk_i) disable iff (!resetn_i)
      $fell(hs_mode_o) |-> scl_i && sda_i) else $error("hs left early");
endmodule

bind aicrp_top aicrp_chk u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .power_up_o(power_up_o), .sample_o(sample_o), .chan_sel_o(chan_sel_o),
  .ext_ref_o(ext_ref_o), .hs_mode_o(hs_mode_o));

`default_nettype wire

// ### bench/aicrp_mst.sv
// two-wire bus master model for the converter's link lines.
// assumes pull-ups on both lines, so a released line reads one.
`timescale 1ns/1ps
`default_nettype none

module aicrp_mst (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // 125 ns steps: far above what the line sampler needs
  task automatic qw(input int n);
    repeat (25 * n) @(posedge clk_i);
  endtask

  task automatic start;
    sda_o <= 1'b1;
    qw(1);
    scl_o <= 1'b1;
    qw(2);
    sda_o <= 1'b0;
    qw(2);
    scl_o <= 1'b0;
  endtask

  task automatic stop;
    qw(1);
    sda_o <= 1'b0;
    qw(1);
    scl_o <= 1'b1;
    qw(2);
    sda_o <= 1'b1;
    qw(2);
  endtask

  // data moves only mid low phase, clear of the device's drive edge
  task automatic xbit(input logic b, output logic r);
    qw(1);
    sda_o <= b;
    qw(1);
    scl_o <= 1'b1;
    qw(2);
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  // a is the master's ninth bit; one releases the line
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(a, k);
  endtask
endmodule

`default_nettype wire

// ### bench/aicrp_tb.sv
// self-checking bench for the converter control block.
// assumes the master model, a comparator stand-in and the bound checker.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e, m) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("mismatch %0t %s got %h exp %h", $time, m, a, e); \
  end \
end

module tb;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl, sdam, sda, sdo, oe, pu, smp, xref, hs, cmp;
  logic [1:0] ch;
  logic [11:0] dac;
  logic [11:0] lvl [4] = '{12'h5a3, 12'h0c1, 12'h7ff, 12'hf3e};
  logic [1:0] chans [$];
  logic [15:0] last_w = 16'h0000;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #2.5 clk_i = ~clk_i;
  initial begin
    #7.3;
    forever #15 link_clk_i = ~link_clk_i;
  end

  // sar settles on lvl exactly: keep bit while input >= trial
  assign cmp = (lvl[ch] >= dac);
  // open drain: the device only ever pulls low, pull-up otherwise
  assign sda = sdam & (~oe | sdo);

  aicrp_mst mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sdam));
  aicrp_top #(.SLAVE_ADDR(ADDR), .RESOLUTION(12)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .cmp_i(cmp),
    .power_up_o(pu), .sample_o(smp), .chan_sel_o(ch), .dac_code_o(dac),
    .ext_ref_o(xref), .hs_mode_o(hs));

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (smp === 1'b1) chans.push_back(ch);
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr_cfg(input logic [7:0] v);
    logic [7:0] q;
    logic a;
    mst.start();
    mst.xbyte({ADDR, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b0, "write addr ack")
    mst.xbyte(v, 1'b1, q, a);
    `CHK(a, 1'b0, "setup ack")
    mst.xbyte(v, 1'b1, q, a);
    `CHK(a, 1'b1, "extra byte ack")
    mst.stop();
    wait_c(200);
  endtask

  task automatic rd_open;
    logic [7:0] q;
    logic a;
    mst.start();
    mst.xbyte({ADDR, 1'b1}, 1'b1, q, a);
    `CHK(a, 1'b0, "read addr ack")
  endtask

  task automatic rd_pair(input logic ak, output logic [15:0] w);
    logic [7:0] hi, lo;
    logic k;
    mst.xbyte(8'hff, 1'b0, hi, k);
    mst.xbyte(8'hff, ak, lo, k);
    w = {hi, lo};
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_reset;
    logic [15:0] w;
    `CHK({pu, hs, xref, oe}, 4'h0, "reset outputs")
    rd_open();
    rd_pair(1'b1, w);
    mst.stop();
    wait_c(3000);
    `CHK(w, 16'h0000, "held word")
    `CHK(chans.size(), 1, "conversions")
    `CHK(chans[0], 2'h0, "first input")
    last_w = {4'h0, lvl[0]};
    $display("test reset done");
  endtask

  // cl holds five expected inputs, first in the low bits
  task automatic t_seq(input logic [7:0] cfg, input logic [9:0] cl);
    logic [15:0] w;
    logic [1:0] c;
    int n0;
    wr_cfg(cfg);
    `CHK(xref, cfg[3], "reference select")
    n0 = chans.size();
    rd_open();
    for (int k = 0; k < 5; k++) begin
      rd_pair(k == 4, w);
      `CHK(w, last_w, "result word")
      c = cl[2*k +: 2];
      last_w = {2'h0, c, lvl[c]};
    end
    mst.stop();
    wait_c(1000);
    for (int k = 0; k < 5; k++) begin
      `CHK(chans[n0 + k], cl[2*k +: 2], "input order")
    end
    `CHK(chans.size(), n0 + 5, "conversion count")
    $display("test sequence %h done", cfg);
  endtask

  task automatic t_none;
    logic [15:0] w;
    int n0;
    wr_cfg(8'h03);
    n0 = chans.size();
    rd_open();
    rd_pair(1'b1, w);
    mst.stop();
    wait_c(1000);
    `CHK(w, last_w, "held word")
    `CHK(chans.size(), n0, "no conversion")
    $display("test no input done");
  endtask

  task automatic t_hs;
    logic [7:0] q;
    logic a;
    mst.start();
    mst.xbyte({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b1, "foreign address")
    mst.start();
    mst.xbyte(8'h0b, 1'b1, q, a);
    `CHK(a, 1'b1, "hs code ack")
    `CHK(hs, 1'b1, "hs mode set")
    wr_cfg(8'hf0);
    `CHK(hs, 1'b0, "hs mode clear")
    $display("test address and hs done");
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    repeat (3) @(posedge link_clk_i);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_c(200);
    t_reset();
    t_seq(8'hb3, 10'h134);
    t_seq(8'hff, 10'h124);
    t_none();
    t_hs();
    stop_test();
  end
endmodule

`default_nettype wire
